// ===== rtl/tsc_pkg.sv
// Package for the timestamp sample capture block: register map, fields, types.
// Assumes a 25 MHz pclk and a 12-bit APB byte address.
package tsc_pkg;
	localparam int          TSC_UNITS      = 2;
	localparam int          TSC_SAMPLES    = 2;
	localparam int          TSC_ROW_W      = 2;
	localparam int          PCLK_PERIOD_NS = 40;
	localparam int          SLOT_NS        = 8;
	localparam int          SLOTS_PER_CLK  = PCLK_PERIOD_NS / SLOT_NS;
	localparam logic [11:0] ADDR_UNIT_IDX  = 12'h520;
	localparam logic [11:0] ADDR_CTL       = 12'h550;
	localparam logic [11:0] ADDR_NS1       = 12'h554;
	localparam logic [11:0] ADDR_S1        = 12'h558;
	localparam logic [11:0] ADDR_PH1       = 12'h55C;
	localparam logic [11:0] ADDR_NS2       = 12'h560;
	localparam logic [11:0] ADDR_S2        = 12'h564;
	localparam logic [11:0] ADDR_PH2       = 12'h568;
	localparam int          IDX_UNIT_BIT   = 8;
	localparam int          NS_EDGE_BIT    = 30;
	localparam int          CTL_RISE_BIT   = 7;
	localparam int          CTL_FALL_BIT   = 6;
	localparam int          CTL_OVF_BIT    = 16;
	localparam int          CTL_CNT_LSB    = 17;
	localparam logic [3:0]  CNT_MAX        = 4'hF;
	localparam logic [3:0]  CNT_RST        = 4'h0;
	localparam logic [2:0]  SLOT_0NS       = 3'h0;
	localparam logic [2:0]  SLOT_8NS       = 3'h1;
	localparam logic [2:0]  SLOT_16NS      = 3'h2;
	localparam logic [2:0]  SLOT_24NS      = 3'h3;
	localparam logic [2:0]  SLOT_32NS      = 3'h4;
	localparam logic [31:0] REG_RST        = 32'h0000_0000;

	typedef struct packed {
		logic [31:0] secs;
		logic [29:0] nanos;
	} tsc_time_t;

	typedef struct packed {
		logic        rising;
		logic [2:0]  slot;
		tsc_time_t   t;
	} tsc_sample_t;

	localparam tsc_sample_t SAMPLE_RST = '0;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ANSWER = 2'b01
	} tsc_apb_st_t;

	function automatic logic [TSC_ROW_W-1:0] row_of(input logic unit, input logic second);
		return {unit, second};
	endfunction

	// Slot index 0..4 of the 40 ns period to its reported code
	function automatic logic [2:0] slot_code(input logic [2:0] idx);
		case (idx)
			3'h0:    return SLOT_0NS;
			3'h1:    return SLOT_8NS;
			3'h2:    return SLOT_16NS;
			3'h3:    return SLOT_24NS;
			default: return SLOT_32NS;
		endcase
	endfunction
endpackage

// ===== rtl/tsc_sample_mem.sv
// Sample store: one row per unit and sample, one write port per unit.
// Assumes each unit writes only its own rows; read data are registered.
`timescale 1ns/1ps
module tsc_sample_mem
	import tsc_pkg::*;
#(
	parameter int UNITS = TSC_UNITS,
	parameter int ROWS  = TSC_UNITS * TSC_SAMPLES
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 ce,
	input  wire logic [UNITS-1:0]     we,
	input  wire logic [UNITS-1:0]     wsecond,
	input  wire tsc_sample_t          wdata [UNITS],
	input  wire logic [TSC_ROW_W-1:0] raddr,
	output tsc_sample_t               rdata
);
	tsc_sample_t mem_r [ROWS];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < ROWS; i++) begin
				mem_r[i] <= SAMPLE_RST;
			end
			rdata <= SAMPLE_RST;
		end else if (ce) begin
			for (int u = 0; u < UNITS; u++) begin
				if (we[u]) begin
					mem_r[row_of(u[0], wsecond[u])] <= wdata[u];
				end
			end
			rdata <= mem_r[raddr];
		end
	end
endmodule // tsc_sample_mem

// ===== rtl/tsc_capture.sv
// Timestamp input units: edge capture of the first two samples, APB registers.
// Assumes event pins and slot indices are asynchronous, ptp_time is on pclk.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// RQ1: Bit 8 of index register selects unit.
// RQ2: Nanoseconds bit 30 shows captured edge polarity.
// RQ3: Nanoseconds in 29:0, bit 31 zero.
// RQ4: Seconds register holds 32-bit captured seconds.
// RQ5: Phase code names 8ns slot, rest zero.
// RQ6: 16ns slot coded 010, avoiding reserved range.
// RQ7: Second sample has its own register set.
// RQ8: Capture only enabled rising or falling edges.
// RQ9: Count edges up to fifteen, at pclk rate.
// RQ10: Samples reset zero, written whole, read-only.
module tsc_capture
	import tsc_pkg::*;
#(
	parameter int NUM_UNITS = TSC_UNITS
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire tsc_time_t                  ptp_time,
	input  wire logic [NUM_UNITS-1:0]       evt_pin,
	input  wire logic [NUM_UNITS-1:0][2:0]  evt_slot
);
	// Event synchronisers and edge history
	logic [NUM_UNITS-1:0]      evt_meta_r;
	logic [NUM_UNITS-1:0]      evt_sync_r;
	logic [NUM_UNITS-1:0]      evt_last_r;
	logic [NUM_UNITS-1:0][2:0] slot_meta_r;
	logic [NUM_UNITS-1:0][2:0] slot_sync_r;

	// Per unit control and count state
	logic [NUM_UNITS-1:0]      rise_en_r;
	logic [NUM_UNITS-1:0]      fall_en_r;
	logic [NUM_UNITS-1:0]      ovf_r;
	logic [3:0]                cnt_r     [NUM_UNITS];
	logic [3:0]                cnt_base  [NUM_UNITS];
	logic [3:0]                cnt_nxt   [NUM_UNITS];
	logic [NUM_UNITS-1:0]      ovf_nxt;
	logic [NUM_UNITS-1:0]      edge_rise;
	logic [NUM_UNITS-1:0]      edge_fall;
	logic [NUM_UNITS-1:0]      take;
	logic [NUM_UNITS-1:0]      rearm;
	logic [NUM_UNITS-1:0]      ctl_wr;
	logic [NUM_UNITS-1:0]      cap_we;
	logic [NUM_UNITS-1:0]      cap_second;
	tsc_sample_t               cap_data  [NUM_UNITS];

	// Register interface
	tsc_apb_st_t               state_r;
	tsc_apb_st_t               state_nxt;
	logic                      unit_sel_r;
	logic [31:0]               prdata_r;
	logic [31:0]               prdata_nxt;
	logic                      slverr_r;
	logic                      access;
	logic                      wr_fire;
	logic                      hit_idx;
	logic                      hit_ctl;
	logic                      hit_ns;
	logic                      hit_s;
	logic                      hit_ph;
	logic                      hit_second;
	logic                      hit_any;
	logic [TSC_ROW_W-1:0]      rd_row;
	tsc_sample_t               rd_sample;
	logic [31:0]               ns_word;
	logic [31:0]               s_word;
	logic [31:0]               ph_word;
	logic [31:0]               ctl_word;
	logic [31:0]               idx_word;

	// ---------------------------------------------------------------
	// Event input: two flip-flops, then edge detection on the second

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_meta_r  <= '0;
			evt_sync_r  <= '0;
			evt_last_r  <= '0;
			slot_meta_r <= '0;
			slot_sync_r <= '0;
		end else if (ce) begin
			evt_meta_r  <= evt_pin;
			evt_sync_r  <= evt_meta_r;
			evt_last_r  <= evt_sync_r;
			slot_meta_r <= evt_slot;
			slot_sync_r <= slot_meta_r;
		end
	end

	assign edge_rise = evt_sync_r & ~evt_last_r;
	assign edge_fall = ~evt_sync_r & evt_last_r;
	assign take      = (edge_rise & rise_en_r) | (edge_fall & fall_en_r); // RQ8

	// ---------------------------------------------------------------
	// Per unit capture and counting

	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
		// Rearm in the same cycle as an edge still counts that edge
		assign ctl_wr[u]        = wr_fire && hit_ctl && (unit_sel_r == 1'(u));
		assign rearm[u]         = ctl_wr[u] && pwdata[CTL_OVF_BIT]; // RQ9
		assign cnt_base[u]      = rearm[u] ? CNT_RST : cnt_r[u];
		assign cap_we[u]        = take[u] && (cnt_base[u] < 4'(TSC_SAMPLES)); // RQ10
		assign cap_second[u]    = cnt_base[u][0]; // RQ7
		assign cap_data[u]      = '{
			rising: edge_rise[u], // RQ2
			slot:   slot_code(slot_sync_r[u]), // RQ6
			t:      ptp_time // RQ4
		};
		assign cnt_nxt[u]       = !take[u] ? cnt_base[u]
			: (cnt_base[u] == CNT_MAX) ? CNT_MAX : cnt_base[u] + 4'h1; // RQ9
		assign ovf_nxt[u]       = (ovf_r[u] && !rearm[u])
			|| (take[u] && (cnt_base[u] == CNT_MAX)); // RQ9
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				cnt_r[i] <= CNT_RST;
			end
			ovf_r     <= '0;
			rise_en_r <= '0;
			fall_en_r <= '0;
		end else if (ce) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				cnt_r[i] <= cnt_nxt[i]; // RQ9
				if (ctl_wr[i]) begin
					rise_en_r[i] <= pwdata[CTL_RISE_BIT]; // RQ8
					fall_en_r[i] <= pwdata[CTL_FALL_BIT]; // RQ8
				end
			end
			ovf_r <= ovf_nxt; // RQ9
		end
	end

	// Whole samples are written in one cycle, so a read never sees a mix
	tsc_sample_mem #(
		.UNITS (NUM_UNITS),
		.ROWS  (NUM_UNITS * TSC_SAMPLES)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.we      (cap_we),
		.wsecond (cap_second),
		.wdata   (cap_data),
		.raddr   (rd_row),
		.rdata   (rd_sample)
	); // RQ10

	// ---------------------------------------------------------------
	// APB decode: the sample row is read during setup, the word
	// is registered in the first access cycle, pready in the second

	assign hit_idx    = (paddr == ADDR_UNIT_IDX);
	assign hit_ctl    = (paddr == ADDR_CTL);
	assign hit_ns     = (paddr == ADDR_NS1) || (paddr == ADDR_NS2);
	assign hit_s      = (paddr == ADDR_S1) || (paddr == ADDR_S2);
	assign hit_ph     = (paddr == ADDR_PH1) || (paddr == ADDR_PH2);
	assign hit_second = (paddr == ADDR_NS2) || (paddr == ADDR_S2) || (paddr == ADDR_PH2); // RQ7
	assign hit_any    = hit_idx || hit_ctl || hit_ns || hit_s || hit_ph;
	assign rd_row     = row_of(unit_sel_r, hit_second); // RQ1

	assign access  = psel && penable;
	assign pready  = access && (state_r == ST_ANSWER) && ce;
	assign wr_fire = pready && pwrite;
	assign pslverr = pready && slverr_r;
	assign prdata  = prdata_r;

	assign ns_word  = {1'b0, rd_sample.rising, rd_sample.t.nanos}; // RQ3
	assign s_word   = rd_sample.t.secs; // RQ4
	assign ph_word  = {29'h0000000, rd_sample.slot}; // RQ5
	assign idx_word = 32'(unit_sel_r) << IDX_UNIT_BIT;
	assign ctl_word = (32'(cnt_r[unit_sel_r]) << CTL_CNT_LSB)
		| (32'(ovf_r[unit_sel_r]) << CTL_OVF_BIT)
		| (32'(rise_en_r[unit_sel_r]) << CTL_RISE_BIT)
		| (32'(fall_en_r[unit_sel_r]) << CTL_FALL_BIT);

	assign prdata_nxt = hit_ns  ? ns_word
		: hit_s   ? s_word
		: hit_ph  ? ph_word
		: hit_ctl ? ctl_word
		: hit_idx ? idx_word
		: REG_RST;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (access) begin
					state_nxt = ST_ANSWER;
				end
			end
			ST_ANSWER: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r  <= ST_IDLE;
			prdata_r <= REG_RST;
			slverr_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			if (access && (state_r == ST_IDLE)) begin
				prdata_r <= pwrite ? REG_RST : prdata_nxt;
				slverr_r <= !hit_any;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_sel_r <= 1'b0;
		end else if (ce && wr_fire && hit_idx) begin
			unit_sel_r <= pwdata[IDX_UNIT_BIT]; // RQ1
		end
	end

	// ---------------------------------------------------------------
	// Checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_UNIT_SEL: assert property ( // RQ1
		ce && wr_fire && hit_idx |=> unit_sel_r == $past(pwdata[IDX_UNIT_BIT])
	) else $error("unit select did not follow index write");

	AST_EDGE_POL: assert property ( // RQ2
		cap_we[0] |-> cap_data[0].rising == (evt_sync_r[0] && !evt_last_r[0])
	) else $error("captured polarity differs from edge");

	AST_NS_RSV: assert property ( // RQ3
		pready && !pwrite && hit_ns |-> !prdata[31]
	) else $error("nanoseconds bit 31 not zero");

	AST_PHASE_FIELD: assert property ( // RQ5
		pready && !pwrite && hit_ph |-> prdata[31:3] == 29'h0000000
			&& prdata[2:0] <= SLOT_32NS
	) else $error("phase register outside defined codes");

	AST_SLOT16: assert property ( // RQ6
		cap_we[0] && slot_sync_r[0] == 3'h2 |-> cap_data[0].slot == SLOT_16NS
	) else $error("16 ns slot code wrong");

	AST_SECOND_ROW: assert property ( // RQ7
		ce && cap_we[0] && cnt_r[0] == 4'h1 && !rearm[0]
			|=> u_mem.mem_r[row_of(1'b0, 1'b1)] == $past(cap_data[0])
	) else $error("second sample not stored in its own row");

	AST_ENABLE: assert property ( // RQ8
		cap_we[0] |-> (edge_rise[0] && rise_en_r[0]) || (edge_fall[0] && fall_en_r[0])
	) else $error("capture of a disabled edge");

	AST_CNT_SAT: assert property ( // RQ9
		ce && take[0] && !rearm[0] && cnt_r[0] == CNT_MAX |=> cnt_r[0] == CNT_MAX && ovf_r[0]
	) else $error("count did not saturate with overflow");

	AST_NO_TEAR: assert property ( // RQ10
		ce && !cap_we[0] |=> u_mem.mem_r[row_of(1'b0, 1'b0)]
			== $past(u_mem.mem_r[row_of(1'b0, 1'b0)])
	) else $error("first sample changed without a capture");

	AST_ANSWER: assert property ( // RQ1
		ce && access && state_r == ST_IDLE ##1 ce && access |-> pready
	) else $error("no answer in second access cycle");

	AST_PREADY_ONE: assert property ( // RQ1
		pready |=> !pready
	) else $error("pready held longer than one cycle");

	AST_IDX_READ: assert property ( // RQ1
		pready && !pwrite && hit_idx |-> prdata == {23'h000000, unit_sel_r, 8'h00}
	) else $error("index register read back wrong");

	AST_UNMAPPED: assert property ( // RQ1
		pready && !hit_any |-> pslverr && prdata == REG_RST
	) else $error("unmapped access not refused");

	AST_SAMPLE_NOERR: assert property ( // RQ10
		pready && (hit_ns || hit_s || hit_ph) |-> !pslverr
	) else $error("sample register access flagged as error");

	AST_WRITE_ZERO: assert property ( // RQ10
		pready && pwrite |-> prdata == REG_RST
	) else $error("write returned read data");

	AST_SLOT_RANGE: assert property ( // RQ5
		cap_we[0] |-> cap_data[0].slot <= SLOT_32NS
	) else $error("reserved phase code captured");

	AST_FIRST_ROW: assert property ( // RQ7
		ce && cap_we[0] && cnt_base[0] == CNT_RST
			|=> u_mem.mem_r[row_of(1'b0, 1'b0)] == $past(cap_data[0])
	) else $error("first sample not stored in its own row");

	AST_UNIT1_ROW: assert property ( // RQ1
		ce && cap_we[1] && cnt_base[1] == CNT_RST
			|=> u_mem.mem_r[row_of(1'b1, 1'b0)] == $past(cap_data[1])
	) else $error("second unit sample not stored in its row");

	AST_THIRD_KEEP: assert property ( // RQ10
		ce && take[0] && cnt_base[0] >= 4'(TSC_SAMPLES)
			|=> $stable(u_mem.mem_r[row_of(1'b0, 1'b0)])
			&& $stable(u_mem.mem_r[row_of(1'b0, 1'b1)])
	) else $error("later edge overwrote a stored sample");

	AST_CNT_STEP: assert property ( // RQ9
		ce && take[0] && !rearm[0] && cnt_r[0] != CNT_MAX
			|=> cnt_r[0] == $past(cnt_r[0]) + 4'h1
	) else $error("count did not step on a taken edge");

	AST_CNT_HOLD: assert property ( // RQ9
		ce && !take[0] && !rearm[0] |=> cnt_r[0] == $past(cnt_r[0])
	) else $error("count moved without an edge");

	AST_REARM: assert property ( // RQ9
		ce && rearm[0] && !take[0] |=> cnt_r[0] == CNT_RST && !ovf_r[0]
	) else $error("rearm did not clear count and overflow");

	AST_OVF_STICKY: assert property ( // RQ9
		ce && ovf_r[0] && !rearm[0] |=> ovf_r[0]
	) else $error("overflow cleared without rearm");

	AST_FREEZE: assert property ( // RQ9
		!ce |=> $stable(cnt_r[0]) && $stable(ovf_r) && $stable(state_r)
			&& $stable(unit_sel_r) && $stable(evt_sync_r)
	) else $error("state moved while clock enable low");
endmodule // tsc_capture

// ===== dv/testbench.sv
// Self-checking bench for the timestamp sample capture block.
// Assumes the APB slave answers with pready and the sample store is read via registers.
`timescale 1ns/1ps
module testbench;
	import tsc_pkg::*;
	logic                 pclk;
	logic                 presetn;
	logic                 ce;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [11:0]          paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	tsc_time_t            ptp_time;
	logic [1:0]           evt_pin;
	logic [1:0][2:0]      evt_slot;
	int                   n_mismatch;
	int                   cmp_count;
	logic [31:0]          last_ns1;
	localparam logic [2:0] EXP_CODE [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

	tsc_capture #(.NUM_UNITS(2)) u_dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ptp_time(ptp_time),
		.evt_pin(evt_pin), .evt_slot(evt_slot)
	);

	always #20 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		chk(32'(n), 32'h2);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk({31'h0, e}, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, exp);
		chk({31'h0, e}, 32'h0);
	endtask

	// Moves one event pin and its slot index together, then lets capture land
	task automatic ev(input int u, input logic lvl, input logic [2:0] s);
		@(posedge pclk);
		evt_pin[u]  <= lvl;
		evt_slot[u] <= s;
		repeat (6) @(posedge pclk);
	endtask

	task automatic t_reset_map;
		logic [31:0] q;
		logic        e;
		foreach (EXP_CODE[i]) rd(ADDR_NS1 + 12'(4 * i), REG_RST);
		rd(ADDR_PH2, REG_RST);
		apb(1'b0, 12'h7F0, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		$display("test reset_map done");
	endtask

	task automatic t_slots;
		tsc_time_t t1;
		tsc_time_t t2;
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_CTL, 32'h0001_00C0);
			t1 = {32'hA000_0000 + 32'(i), 30'h1234_5670 + 30'(i)};
			t2 = {32'h5000_0100 + 32'(i), 30'h0ABC_DE00 + 30'(i)};
			ptp_time <= t1;
			ev(0, 1'b1, 3'(i));
			ptp_time <= t2;
			ev(0, 1'b0, 3'(4 - i));
			rd(ADDR_NS1, {2'b01, t1.nanos});
			rd(ADDR_S1, t1.secs);
			rd(ADDR_PH1, {29'h0, EXP_CODE[i]});
			rd(ADDR_NS2, {2'b00, t2.nanos});
			rd(ADDR_S2, t2.secs);
			rd(ADDR_PH2, {29'h0, EXP_CODE[4 - i]});
			rd(ADDR_CTL, 32'h0004_00C0);
		end
		$display("test slots done");
	endtask

	task automatic t_enable;
		wr(ADDR_CTL, 32'h0001_0080);
		ev(0, 1'b1, 3'h1);
		ev(0, 1'b0, 3'h2);
		rd(ADDR_CTL, 32'h0002_0080);
		wr(ADDR_CTL, 32'h0001_0040);
		ev(0, 1'b1, 3'h1);
		rd(ADDR_CTL, 32'h0000_0040);
		ev(0, 1'b0, 3'h3);
		rd(ADDR_CTL, 32'h0002_0040);
		rd(ADDR_PH1, 32'h0000_0003);
		$display("test enable done");
	endtask

	task automatic t_saturate;
		tsc_time_t ts;
		ts = {32'h0000_0042, 30'h0000_1111};
		ptp_time <= ts;
		last_ns1 = {2'b01, ts.nanos};
		wr(ADDR_CTL, 32'h0001_00C0);
		for (int i = 0; i < 15; i++) begin
			@(posedge pclk);
			evt_pin[0] <= ~evt_pin[0];
		end
		repeat (6) @(posedge pclk);
		rd(ADDR_CTL, 32'h001E_00C0);
		ev(0, 1'b0, 3'h0);
		rd(ADDR_CTL, 32'h001F_00C0);
		rd(ADDR_NS1, last_ns1);
		rd(ADDR_NS2, {2'b00, ts.nanos});
		$display("test saturate done");
	endtask

	task automatic t_units;
		tsc_time_t t1;
		t1 = {32'h0F0F_0F0F, 30'h3000_0001};
		wr(ADDR_UNIT_IDX, 32'h0000_0100);
		rd(ADDR_NS1, REG_RST);
		wr(ADDR_CTL, 32'h0001_0080);
		ptp_time <= t1;
		ev(1, 1'b1, 3'h3);
		rd(ADDR_NS1, {2'b01, t1.nanos});
		wr(ADDR_NS1, 32'hFFFF_FFFF);
		wr(ADDR_PH1, 32'hFFFF_FFFF);
		rd(ADDR_NS1, {2'b01, t1.nanos});
		rd(ADDR_PH1, 32'h0000_0003);
		wr(ADDR_UNIT_IDX, 32'h0000_0000);
		rd(ADDR_NS1, last_ns1);
		$display("test units done");
	endtask

	// Clock enable low freezes the synchronisers: a pulse inside it is lost
	task automatic t_hold;
		wr(ADDR_CTL, 32'h0001_00C0);
		@(posedge pclk);
		ce <= 1'b0;
		ev(0, 1'b1, 3'h2);
		ev(0, 1'b0, 3'h2);
		@(posedge pclk);
		ce <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(ADDR_CTL, 32'h0000_00C0);
		@(posedge pclk);
		ce <= 1'b0;
		ev(0, 1'b1, 3'h2);
		@(posedge pclk);
		ce <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(ADDR_CTL, 32'h0002_00C0);
		rd(ADDR_PH1, 32'h0000_0002);
		$display("test hold done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ptp_time = '0;
		evt_pin = 2'b00;
		evt_slot = '0;
		n_mismatch = 0;
		cmp_count = 0;
		last_ns1 = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset_map();
		t_slots();
		t_enable();
		t_saturate();
		t_units();
		t_hold();
		report_and_stop();
	end

	initial begin
		#(40 * 20000);
		n_mismatch++;
		report_and_stop();
	end
endmodule // testbench
